// *** sr_status_srq.sv ***
/*
  status register, request mask, service request line and interface
  message handling of the instrument's bus port.
  assumes bytes, handshakes and instrument events arrive as one-cycle
  strobes synchronous to i_mclk; the command parser and measurement
  engine sit outside and talk through the strobes below.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sr_cfg.svh"

module sr_status_srq #(
  parameter int MASK_W = `SR_MASK_W
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // bus lines
  input wire logic i_atn,
  input wire logic i_ifc,
  input wire logic i_ren,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic [4:0] i_my_addr,
  input wire logic i_talk_only_sw,
  input wire logic i_talk_byte_taken,
  // instrument events
  input wire logic i_overrange,
  input wire logic i_front_req,
  input wire logic i_cal_done,
  input wire logic i_error,
  input wire logic i_obuf_load,
  input wire logic i_obuf_read,
  input wire logic i_dev_cmd,
  input wire logic i_new_string,
  input wire logic i_trigger,
  input wire logic i_meas_busy,
  input wire logic i_clear_exec,
  // mask commands from the parser, two decimal digits
  input wire logic i_mask_set,
  input wire logic [3:0] i_mask_tens,
  input wire logic [3:0] i_mask_ones,
  input wire logic i_mask_query,
  // bus outputs
  output logic o_srq_n,
  output logic o_talk_sel_status,
  output logic [7:0] o_talk_byte,
  output logic o_talker,
  output logic o_listener,
  // toward the input buffer and instrument
  output logic o_ibuf_write,
  output logic [7:0] o_ibuf_char,
  output logic o_ibuf_front,
  output logic o_ibuf_flush,
  output logic o_string_end,
  output logic o_clear_pending,
  output logic o_mask_clear,
  // readback
  output logic [7:0] o_status,
  output logic [5:0] o_mask,
  output logic o_mask_resp_valid,
  output logic [7:0] o_mask_resp,
  output logic o_remote,
  output logic o_lockout
);

  logic [7:0] status_q, status_d;
  logic [MASK_W-1:0] mask_q, mask_d;
  logic req_q;
  sr_pkg::talk_state_t talk_q, talk_d;
  logic listen_q, spoll_q, remote_q, lockout_q, clr_wait_q, to_seen_q;
  logic [7:0] talk_byte_q;
  logic srq_n_q, sel_q, talker_q, pend_q;
  logic ibuf_w_q, ibuf_front_q, flush_q, str_end_q;
  logic [7:0] ibuf_char_q;
  logic mresp_v_q;
  logic [7:0] mresp_q;

  wire logic [2:0] cls;
  wire logic my_lsn, my_tlk, oth_tlk;

  sr_msg_decode u_dec (
    .i_atn(i_atn),
    .i_valid(i_byte_valid),
    .i_byte(i_byte),
    .i_my_addr(i_my_addr),
    .o_class(cls),
    .o_my_listen(my_lsn),
    .o_my_talk(my_tlk),
    .o_other_talk(oth_tlk)
  );

  // two decimal digits to binary, cut to 8 bits; the mask load cuts it to the mask width
  function automatic logic [7:0] bcd_to_bin(input logic [3:0] t, o);
    bcd_to_bin = 8'((t * 4'ha) + o);
  endfunction : bcd_to_bin

  // binary back to two ascii-free decimal digits for the query answer
  function automatic logic [7:0] bin_to_bcd(input logic [7:0] b);
    logic [7:0] t;
    t = b / 8'h0a;
    bin_to_bcd = {t[3:0], 4'(b - t * 8'h0a)};
  endfunction : bin_to_bcd

  wire logic [6:0] code = i_byte[6:0];
  wire logic uc = cls == sr_pkg::MSG_UNIVERSAL;
  wire logic ac = cls == sr_pkg::MSG_ADDRESSED && listen_q;
  wire logic adr = cls == sr_pkg::MSG_ADDRESS;
  wire logic got_dcl = uc && code == `SR_MSG_DCL;
  wire logic got_sdc = ac && code == `SR_MSG_SDC;
  wire logic got_clear = got_dcl || got_sdc;
  wire logic got_get = ac && code == `SR_MSG_GET;
  wire logic got_gtl = ac && code == `SR_MSG_GTL;
  wire logic got_llo = uc && code == `SR_MSG_LLO;
  wire logic got_spe = uc && code == `SR_MSG_SPE;
  wire logic got_spd = uc && code == `SR_MSG_SPD;
  wire logic got_unl = adr && code == `SR_MSG_UNL;
  wire logic got_unt = adr && code == `SR_MSG_UNT;
  wire logic [7:0] mask_bin = bcd_to_bin(i_mask_tens, i_mask_ones);

  // clear terms shared by several status bits
  wire logic clr_cmd = i_dev_cmd || i_new_string;
  wire logic clr_trig = i_trigger || got_get;
  wire logic clr_read = i_obuf_read;
  // an error loads an error message into the output buffer as well
  wire logic load_evt = i_obuf_load || i_error;
  wire logic [5:0] low_next = status_d[5:0];
  wire logic [5:0] mask_ext = 6'(mask_q);

  // status bits: set wins over clear in the same cycle
  always_comb begin
    status_d = status_q;
    if (clr_cmd || clr_trig || clr_read)
      status_d[`SR_BIT_OVERRANGE] = 1'b0;
    if (i_overrange)
      status_d[`SR_BIT_OVERRANGE] = 1'b1;
    if (clr_cmd)
      status_d[`SR_BIT_FRONT_REQ] = 1'b0;
    if (i_front_req)
      status_d[`SR_BIT_FRONT_REQ] = 1'b1;
    if (clr_cmd)
      status_d[`SR_BIT_CAL_DONE] = 1'b0;
    if (i_cal_done)
      status_d[`SR_BIT_CAL_DONE] = 1'b1;
    if (clr_cmd || clr_trig || clr_read)
      status_d[`SR_BIT_DATA_AVAIL] = 1'b0;
    if (load_evt)
      status_d[`SR_BIT_DATA_AVAIL] = 1'b1;
    if (clr_cmd || clr_read)
      status_d[`SR_BIT_ANY_ERROR] = 1'b0;
    if (i_error)
      status_d[`SR_BIT_ANY_ERROR] = 1'b1;
    status_d[`SR_BIT_UNUSED2] = 1'b0;
    status_d[`SR_BIT_UNUSED8] = 1'b0;
    status_d[`SR_BIT_REQUEST] = req_q;
  end

  // mask updates: clear wins, as the clear must hold requests off
  always_comb begin
    mask_d = mask_q;
    if (i_mask_set)
      mask_d = MASK_W'(mask_bin);
    if (got_clear || i_clear_exec)
      mask_d = MASK_W'(`SR_MASK_RESET);
  end

  // talker state; talk-only is taken after reset and on every ifc
  always_comb begin
    talk_d = talk_q;
    if (my_tlk)
      talk_d = sr_pkg::TALK_ADDRESSED;
    else if ((oth_tlk || got_unt) && talk_q == sr_pkg::TALK_ADDRESSED)
      talk_d = sr_pkg::TALK_IDLE;
    if (i_ifc || !to_seen_q)
      talk_d = i_talk_only_sw ? sr_pkg::TALK_ONLY : sr_pkg::TALK_IDLE;
  end

  // request bit: taken on each buffer load, dropped when masked bits clear
  wire logic masked_any = |(low_next & mask_ext);
  wire logic req_d = load_evt ? masked_any : (req_q && masked_any);

  // status register, mask and request
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      status_q <= `SR_STATUS_RESET;
      mask_q <= MASK_W'(`SR_MASK_RESET);
      req_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      req_q <= req_d;
    end
  end

  // talker and listener state; ifc touches only these flags
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      talk_q <= sr_pkg::TALK_IDLE;
      talker_q <= 1'b0;
      listen_q <= 1'b0;
      spoll_q <= 1'b0;
    end else begin
      talk_q <= talk_d;
      talker_q <= talk_d != sr_pkg::TALK_IDLE;
      if (i_ifc) begin
        listen_q <= 1'b0;
        spoll_q <= 1'b0;
      end else begin
        if (my_lsn)
          listen_q <= 1'b1;
        else if (got_unl)
          listen_q <= 1'b0;
        if (got_spe)
          spoll_q <= 1'b1;
        else if (got_spd)
          spoll_q <= 1'b0;
      end
    end
  end

  // first edge after reset takes the switch; reset may load only constants
  always_ff @(posedge i_mclk) begin
    if (!i_nrst)
      to_seen_q <= 1'b0;
    else
      to_seen_q <= 1'b1;
  end

  // remote and lockout
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      remote_q <= 1'b0;
      lockout_q <= 1'b0;
    end else if (!i_ren) begin
      remote_q <= 1'b0;
      lockout_q <= 1'b0;
    end else begin
      if (my_lsn)
        remote_q <= 1'b1;
      else if (got_gtl)
        remote_q <= 1'b0;
      if (got_llo)
        lockout_q <= 1'b1;
    end
  end

  // input buffer traffic: only data, dcl/sdc and get are written
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      ibuf_w_q <= 1'b0;
      ibuf_char_q <= 8'h00;
      ibuf_front_q <= 1'b0;
      flush_q <= 1'b0;
      str_end_q <= 1'b0;
      clr_wait_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      ibuf_w_q <= (cls == sr_pkg::MSG_DATA) || got_clear || got_get;
      ibuf_char_q <= got_clear ? `SR_CHAR_CLEAR :
                     got_get ? `SR_CHAR_TRIG : i_byte;
      ibuf_front_q <= got_clear;
      flush_q <= got_clear;
      str_end_q <= got_get;
      // clear is released to the parser only once the reading is done
      if (got_clear)
        clr_wait_q <= 1'b1;
      else if (i_clear_exec)
        clr_wait_q <= 1'b0;
      pend_q <= (got_clear || (clr_wait_q && !i_clear_exec))
                && !i_meas_busy;
    end
  end

  // bus outputs: poll data comes from the status register directly,
  // so the output buffer is never popped during a poll
  wire logic poll_talk = spoll_q && !i_atn;
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      srq_n_q <= 1'b1;
      sel_q <= 1'b0;
      talk_byte_q <= 8'h00;
      mresp_v_q <= 1'b0;
      mresp_q <= 8'h00;
    end else begin
      srq_n_q <= !req_q;
      sel_q <= poll_talk;
      talk_byte_q <= status_d;
      mresp_v_q <= i_mask_query;
      mresp_q <= bin_to_bcd(8'(mask_q));
    end
  end

  assign o_srq_n = srq_n_q;
  assign o_talk_sel_status = sel_q;
  assign o_talk_byte = talk_byte_q;
  assign o_talker = talker_q;
  assign o_listener = listen_q;
  assign o_ibuf_write = ibuf_w_q;
  assign o_ibuf_char = ibuf_char_q;
  assign o_ibuf_front = ibuf_front_q;
  assign o_ibuf_flush = flush_q;
  assign o_string_end = str_end_q;
  assign o_clear_pending = pend_q;
  assign o_mask_clear = flush_q;
  assign o_status = status_q;
  assign o_mask = 6'(mask_q);
  assign o_mask_resp_valid = mresp_v_q;
  assign o_mask_resp = mresp_q;
  assign o_remote = remote_q;
  assign o_lockout = lockout_q;

  // talk handshake is consumed outside; kept as a port for the talker
  wire logic unused_ok = i_talk_byte_taken;

endmodule : sr_status_srq
`default_nettype wire

// *** sr_cfg.svh ***
/*
  constants for the bus status and service request block: status bit
  positions, interface message codes, mask width and reset values.
  assumes the includer is a design or package file of this block.
*/
`ifndef SR_CFG_SVH
`define SR_CFG_SVH

// status bit positions, zero based (poll bit n sits at index n-1)
`define SR_BIT_OVERRANGE 0
`define SR_BIT_UNUSED2 1
`define SR_BIT_FRONT_REQ 2
`define SR_BIT_CAL_DONE 3
`define SR_BIT_DATA_AVAIL 4
`define SR_BIT_ANY_ERROR 5
`define SR_BIT_REQUEST 6
`define SR_BIT_UNUSED8 7

`define SR_MASK_W 6
`define SR_MASK_RESET 6'h00
`define SR_STATUS_RESET 8'h00

// multiline interface message codes, seven bits, parity bit ignored
`define SR_MSG_GTL 7'h01
`define SR_MSG_SDC 7'h04
`define SR_MSG_GET 7'h08
`define SR_MSG_LLO 7'h11
`define SR_MSG_DCL 7'h14
`define SR_MSG_SPE 7'h18
`define SR_MSG_SPD 7'h19
`define SR_MSG_UNL 7'h3f
`define SR_MSG_UNT 7'h5f
`define SR_LAG_BASE 2'b01
`define SR_TAG_BASE 2'b10

// input buffer special characters
`define SR_CHAR_CLEAR 8'h2a
`define SR_CHAR_TRIG 8'h3f

`endif

// *** sr_pkg.sv ***
/*
  types shared by the status and service request block.
  assumes sr_cfg.svh is on the include path.
*/
`default_nettype none
`include "sr_cfg.svh"

package sr_pkg;

  // talker function state of the bus interface
  typedef enum logic [1:0] {
    TALK_IDLE = 2'b00,
    TALK_ADDRESSED = 2'b01,
    TALK_ONLY = 2'b10
  } talk_state_t;

  // what the interface does with a multiline byte
  typedef enum logic [2:0] {
    MSG_NONE = 3'b000,
    MSG_UNIVERSAL = 3'b001,
    MSG_ADDRESSED = 3'b010,
    MSG_ADDRESS = 3'b011,
    MSG_DATA = 3'b100
  } msg_class_t;

endpackage : sr_pkg
`default_nettype wire

// *** sr_msg_decode.sv ***
/*
  classifies one multiline byte from the bus into data, address,
  universal or addressed messages, and compares addresses.
  assumes the byte is presented with its strobe in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sr_cfg.svh"

module sr_msg_decode (
  // incoming byte
  input wire logic i_atn,
  input wire logic i_valid,
  input wire logic [7:0] i_byte,
  input wire logic [4:0] i_my_addr,
  // decoded class and flags
  output logic [2:0] o_class,
  output logic o_my_listen,
  output logic o_my_talk,
  output logic o_other_talk
);

  wire logic [6:0] code = i_byte[6:0];
  wire logic is_lag = code[6:5] == `SR_LAG_BASE;
  wire logic is_tag = code[6:5] == `SR_TAG_BASE;
  wire logic is_uc = code[6:4] == 3'h1;
  wire logic is_ac = code[6:4] == 3'h0;
  wire logic cmd = i_valid && i_atn;

  // atn decides between interface messages and device data
  assign o_class = !i_valid ? sr_pkg::MSG_NONE :
                   !i_atn ? sr_pkg::MSG_DATA :
                   (is_lag || is_tag) ? sr_pkg::MSG_ADDRESS :
                   is_uc ? sr_pkg::MSG_UNIVERSAL :
                   is_ac ? sr_pkg::MSG_ADDRESSED : sr_pkg::MSG_NONE;
  // address hits count only for a strobed byte under atn, so data bytes
  // or a released bus can never address or unaddress the device
  assign o_my_listen = cmd && is_lag && code[4:0] == i_my_addr;
  assign o_my_talk = cmd && is_tag && code[4:0] == i_my_addr;
  assign o_other_talk = cmd && is_tag && code[4:0] != i_my_addr;

endmodule : sr_msg_decode
`default_nettype wire

// *** sr_status_srq_monitor.sv ***
/*
  checker for the status and service request block: ties events,
  bus bytes and parser strobes to the outputs they must produce.
  assumes a single i_mclk domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sr_cfg.svh"

module sr_status_srq_monitor #(
  parameter int MASK_W = `SR_MASK_W
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // bus lines
  input wire logic i_atn,
  input wire logic i_ifc,
  input wire logic i_ren,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  // instrument events and parser strobes
  input wire logic i_overrange,
  input wire logic i_front_req,
  input wire logic i_cal_done,
  input wire logic i_error,
  input wire logic i_obuf_load,
  input wire logic i_dev_cmd,
  input wire logic i_meas_busy,
  input wire logic i_clear_exec,
  input wire logic i_mask_set,
  input wire logic [3:0] i_mask_tens,
  input wire logic [3:0] i_mask_ones,
  // outputs watched
  input wire logic o_srq_n,
  input wire logic o_talk_sel_status,
  input wire logic o_ibuf_write,
  input wire logic [7:0] o_ibuf_char,
  input wire logic o_ibuf_front,
  input wire logic o_ibuf_flush,
  input wire logic o_clear_pending,
  input wire logic [7:0] o_status,
  input wire logic [5:0] o_mask,
  input wire logic o_remote,
  input wire logic o_lockout
);
  // message decode and expected mask; 8 bits so tens*10 cannot wrap
  wire cmd = i_byte_valid && i_atn;
  wire [6:0] code = i_byte[6:0];
  wire [7:0] mval = 8'(i_mask_tens) * 8'd10 + 8'(i_mask_ones);
  wire any_set = i_overrange || i_front_req || i_cal_done || i_error;
  logic [MASK_W-1:0] mexp_q;

  // remembers the mask the parser asked for, compared one cycle later
  always_ff @(posedge i_mclk) begin
    mexp_q <= mval[MASK_W-1:0];
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  property p_rsvd; !o_status[1] && !o_status[7]; endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("unused status bit set");
  property p_ovr; i_overrange |=> o_status[0]; endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrange bit not set");
  property p_err; i_error |=> o_status[5] && o_status[4]; endproperty
  a_err: assert property (p_err)
    else $error("error did not set bits 6 and 5");
  property p_clr;
    i_dev_cmd && !any_set && !i_obuf_load |=> (o_status & 8'h3d) == 8'h00;
  endproperty
  a_clr: assert property (p_clr)
    else $error("device command left status bits set");
  property p_srq; o_srq_n == !o_status[6]; endproperty
  a_srq: assert property (p_srq)
    else $error("service line disagrees with request bit");
  property p_mask;
    i_mask_set && !i_byte_valid && !i_clear_exec |=> o_mask == mexp_q;
  endproperty
  a_mask: assert property (p_mask)
    else $error("mask not loaded from decimal digits");
  property p_dcl;
    cmd && code == `SR_MSG_DCL |=> o_ibuf_write && o_ibuf_front &&
      o_ibuf_flush && o_ibuf_char == `SR_CHAR_CLEAR;
  endproperty
  a_dcl: assert property (p_dcl)
    else $error("device clear not queued at head");
  property p_dclmask; cmd && code == `SR_MSG_DCL |=> o_mask == 6'h00;
  endproperty
  a_dclmask: assert property (p_dclmask)
    else $error("device clear kept the mask");
  property p_addr; cmd && code[6:5] inside {2'b01, 2'b10} |=> !o_ibuf_write;
  endproperty
  a_addr: assert property (p_addr)
    else $error("address byte entered input buffer");
  property p_data; i_byte_valid && !i_atn |=> !o_ibuf_flush; endproperty
  a_data: assert property (p_data)
    else $error("data byte acted as interface message");
  property p_pend; o_clear_pending |-> !$past(i_meas_busy); endproperty
  a_pend: assert property (p_pend)
    else $error("clear released during measurement");
  property p_ren; $fell(i_ren) |=> !o_remote && !o_lockout; endproperty
  a_ren: assert property (p_ren)
    else $error("remote or lockout kept after ren dropped");
  property p_spe;
    cmd && code == `SR_MSG_SPE ##1 !i_atn && !i_ifc |=> o_talk_sel_status;
  endproperty
  a_spe: assert property (p_spe)
    else $error("poll state not entered");
endmodule : sr_status_srq_monitor

bind sr_status_srq sr_status_srq_monitor #(.MASK_W(MASK_W)) u_mon (.*);
`default_nettype wire

// *** sr_ctrl_model.sv ***
/*
  behavioural system controller: sends multiline bytes under attention
  and drives the uniline ifc and ren lines.
  assumes callers enter its tasks on a falling edge of i_mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module sr_ctrl_model (
  // clock
  input wire logic i_mclk,
  // uniline and multiline bus lines
  output logic o_atn,
  output logic o_ifc,
  output logic o_ren,
  output logic o_valid,
  output logic [7:0] o_byte
);
  // idle bus at time zero
  initial begin
    o_atn = 1'b0;
    o_ifc = 1'b0;
    o_ren = 1'b0;
    o_valid = 1'b0;
    o_byte = 8'h00;
  end

  // one byte, atn says interface message or data; released lines show
  // the inverse so a stale copy can never pass for the real byte
  task automatic send(input logic atn, input logic [7:0] b);
    @(negedge i_mclk);
    o_atn = atn;
    o_valid = 1'b1;
    o_byte = b;
    @(negedge i_mclk);
    o_valid = 1'b0;
    o_byte = ~b;
  endtask : send

  // level lines, changed at the caller's edge
  task automatic lines(input logic atn, input logic ren);
    o_atn = atn;
    o_ren = ren;
  endtask : lines

  // interface clear, one cycle wide
  task automatic pulse_ifc();
    @(negedge i_mclk);
    o_ifc = 1'b1;
    @(negedge i_mclk);
    o_ifc = 1'b0;
  endtask : pulse_ifc
endmodule : sr_ctrl_model
`default_nettype wire

// *** sr_status_srq_tb.sv ***
/*
  self-checking bench for the status and service request block.
  assumes sr_ctrl_model stands in for the controller; inputs change
  on the falling edge of a 20 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sr_cfg.svh"

module sr_status_srq_tb;
  localparam logic [4:0] ADDR = 5'h0b;
  logic i_mclk, i_nrst, i_meas_busy, i_clear_exec, i_talk_only_sw;
  logic i_mask_set, i_mask_query, i_talk_byte_taken;
  logic [3:0] i_mask_tens, i_mask_ones;
  logic [8:0] ev;
  wire i_overrange = ev[0], i_front_req = ev[1], i_cal_done = ev[2];
  wire i_error = ev[3], i_obuf_load = ev[4], i_obuf_read = ev[5];
  wire i_dev_cmd = ev[6], i_new_string = ev[7], i_trigger = ev[8];
  wire i_atn, i_ifc, i_ren, i_byte_valid;
  wire [7:0] i_byte;
  wire [4:0] i_my_addr = ADDR;
  wire o_srq_n, o_talk_sel_status, o_talker, o_listener, o_ibuf_write;
  wire o_ibuf_front, o_ibuf_flush, o_string_end, o_clear_pending;
  wire o_mask_clear, o_mask_resp_valid, o_remote, o_lockout;
  wire [7:0] o_talk_byte, o_ibuf_char, o_status, o_mask_resp;
  wire [5:0] o_mask;
  int err_total, cmp_count;
  // flags packed so one compare covers a whole transfer
  wire [7:0] ib = {2'b00, o_mask_clear, o_ibuf_write, o_ibuf_front,
    o_ibuf_flush,
    o_string_end, o_clear_pending};
  wire [7:0] bus = {2'b00, o_talk_sel_status, o_talker, o_listener,
    o_remote, o_lockout, o_srq_n};
  // event steps and the status each must leave, mask at zero
  logic [8:0] ev_t [11] = '{9'h001, 9'h020, 9'h002, 9'h004, 9'h010,
    9'h100, 9'h040, 9'h008, 9'h020, 9'h011, 9'h080};
  logic [7:0] st_t [11] = '{8'h01, 8'h00, 8'h04, 8'h0c, 8'h1c, 8'h0c,
    8'h00, 8'h30, 8'h00, 8'h11, 8'h00};

  sr_status_srq dut (.*);
  sr_ctrl_model ctl (.i_mclk(i_mclk), .o_atn(i_atn), .o_ifc(i_ifc),
    .o_ren(i_ren), .o_valid(i_byte_valid), .o_byte(i_byte));

  // clock
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic pulse(input logic [8:0] e);
    @(negedge i_mclk);
    ev = e;
    @(negedge i_mclk);
    ev = 9'h000;
  endtask : pulse

  task automatic mask_io(input logic [3:0] t, input logic [3:0] o);
    @(negedge i_mclk);
    i_mask_set = 1'b1;
    i_mask_tens = t;
    i_mask_ones = o;
    @(negedge i_mclk);
    i_mask_set = 1'b0;
    i_mask_query = 1'b1;
    chk(8'(o_mask), (8'(t) * 8'd10 + 8'(o)) & 8'h3f);
    @(negedge i_mclk);
    i_mask_query = 1'b0;
    chk(8'(o_mask_resp_valid), 8'h01);
    chk(o_mask_resp, {t, o});
  endtask : mask_io

  task automatic t_status();
    for (int k = 0; k < 11; k++) begin
      pulse(ev_t[k]);
      chk(o_status, st_t[k]);
    end
    $display("status test done");
  endtask : t_status

  task automatic t_mask();
    mask_io(4'h3, 4'h5);
    mask_io(4'h0, 4'h4);
    pulse(9'h002);
    pulse(9'h010);
    @(negedge i_mclk);
    chk(o_status, 8'h54);
    chk(bus, 8'h00);
    i_meas_busy = 1'b1;
    ctl.send(1'b1, {1'b0, `SR_MSG_DCL});
    chk(ib, 8'h3c);
    chk(o_ibuf_char, `SR_CHAR_CLEAR);
    chk(8'(o_mask), 8'h00);
    i_meas_busy = 1'b0;
    @(negedge i_mclk);
    chk(ib, 8'h01);
    i_clear_exec = 1'b1;
    @(negedge i_mclk);
    i_clear_exec = 1'b0;
    chk(ib, 8'h00);
    pulse(9'h040);
    @(negedge i_mclk);
    chk(o_status, 8'h00);
    chk(bus, 8'h01);
    $display("mask test done");
  endtask : t_mask

  task automatic t_bus();
    ctl.lines(1'b1, 1'b1);
    ctl.send(1'b1, {3'b001, ADDR});
    chk(ib, 8'h00);
    chk(bus, 8'h0d);
    ctl.send(1'b1, {1'b0, `SR_MSG_LLO});
    chk(bus, 8'h0f);
    ctl.send(1'b1, {1'b0, `SR_MSG_GET});
    chk(ib, 8'h12);
    chk(o_ibuf_char, `SR_CHAR_TRIG);
    ctl.send(1'b1, {1'b0, `SR_MSG_SDC});
    chk(ib, 8'h3d);
    ctl.send(1'b1, {1'b0, `SR_MSG_UNL});
    chk(bus, 8'h07);
    ctl.send(1'b1, {1'b0, `SR_MSG_SDC});
    chk(ib, 8'h01);
    ctl.send(1'b0, {1'b0, `SR_MSG_DCL});
    chk(ib, 8'h11);
    chk(o_ibuf_char, 8'h14);
    ctl.lines(1'b1, 1'b0);
    @(negedge i_mclk);
    chk(bus, 8'h01);
    $display("bus test done");
  endtask : t_bus

  task automatic t_poll();
    pulse(9'h010);
    ctl.send(1'b1, {3'b010, ADDR});
    chk(bus, 8'h11);
    ctl.send(1'b1, {1'b0, `SR_MSG_SPE});
    ctl.lines(1'b0, 1'b0);
    @(negedge i_mclk);
    chk(bus, 8'h31);
    chk(o_talk_byte, 8'h10);
    chk(o_status, 8'h10);
    ctl.lines(1'b1, 1'b0);
    ctl.send(1'b1, {1'b0, `SR_MSG_SPD});
    chk(bus, 8'h11);
    ctl.send(1'b1, {1'b0, `SR_MSG_UNT});
    chk(bus, 8'h01);
    $display("poll test done");
  endtask : t_poll

  task automatic t_ifc();
    mask_io(4'h0, 4'h1);
    i_talk_only_sw = 1'b1;
    ctl.pulse_ifc();
    chk(bus, 8'h11);
    chk(8'(o_mask), 8'h01);
    // a reset in mid-run must reload the mask and take the switch again
    i_nrst = 1'b0;
    @(negedge i_mclk);
    i_nrst = 1'b1;
    chk(8'(o_mask), 8'h00);
    @(negedge i_mclk);
    chk(bus, 8'h11);
    $display("ifc test done");
  endtask : t_ifc

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // a hang costs a mismatch; the run needs well under 300 cycles
  initial begin
    repeat (3000) @(posedge i_mclk);
    err_total++;
    tally_and_finish();
  end

  // reset for 12 cycles, then the scenarios
  initial begin
    {i_nrst, i_meas_busy, i_clear_exec, i_talk_only_sw} = 4'h0;
    {i_mask_set, i_mask_query, i_talk_byte_taken} = 3'b000;
    {i_mask_tens, i_mask_ones} = 8'h00;
    ev = 9'h000;
    repeat (12) @(negedge i_mclk);
    i_nrst = 1'b1;
    chk(o_status, 8'h00);
    chk(8'(o_mask), 8'h00);
    chk(bus, 8'h01);
    t_status();
    t_mask();
    t_bus();
    t_poll();
    t_ifc();
    tally_and_finish();
  end
endmodule : sr_status_srq_tb
`default_nettype wire
